// File: bmfbi_regs.vh
// constants for the burst multiplexed flash bus interface
`ifndef BMFBI_REGS_VH
`define BMFBI_REGS_VH

`define BMFBI_ADDR_W        24
`define BMFBI_WORD_ADDR_W   23
`define BMFBI_DATA_W        16
`define BMFBI_BANKS         8
`define BMFBI_BANK_SHIFT    20
`define BMFBI_WBUF_WORDS    32
`define BMFBI_ERASE_WORD    16'hFFFF
`define BMFBI_LAT_CYCLES    4'h4
`define BMFBI_WRAP_CONT     2'h0
`define BMFBI_WRAP_8        2'h1
`define BMFBI_WRAP_16       2'h2
`define BMFBI_BOOT_SEC_WORDS 23'h004000
`define BMFBI_MAIN_SEC_WORDS 23'h010000

`endif

// File: bmfbi_device.v
// device-side bus interface of a burst multiplexed nor flash
`timescale 1ns/1ps
`default_nettype none
`include "bmfbi_regs.vh"

// Behaviour
// RQ1: first clock edge with address strobe low latches address, starts burst
// RQ2: after first burst word, each later clock edge advances burst address
// RQ3: host holds clock low during asynchronous accesses
// RQ4: low sixteen address bits share data lines; strobe low marks valid address
// RQ5: strobe high ignores address inputs, keeps captured address
// RQ6: ready output high when valid burst data is on the bus
// RQ7: hardware reset low returns device to array read state
// RQ8: acceleration at high voltage speeds programming and enters unlock bypass
// RQ9: acceleration input low refuses all program and erase operations
// RQ10: every read transfer returns a full sixteen-bit word
// RQ11: every write transfer accepts a full sixteen-bit word
// RQ12: eight banks; program or erase in one, reads in others
// RQ13: sector is smallest erase unit; erase sets bits to one
// RQ14: main sectors 128 KB; four 32 KB boot sectors top or bottom
// RQ15: programming through 64-byte buffer, one to thirty-two words each
// RQ16: continuous bursts and wrapped bursts in aligned 8 or 16 word groups
// RQ17: wrapped burst runs to group end then restarts at group start
// RQ18: wrapped burst finishes on word before starting word
// RQ19: ready stays low during initial burst latency
// RQ20: host expects no valid data from a busy bank
module bmfbi_device (
	input  wire        clk,
	input  wire        rstn,
	input  wire        chip_enable_n,
	input  wire        output_enable_n,
	input  wire        write_enable_n,
	input  wire        address_valid_strobe_n,
	input  wire [15:0] muxed_addr_data_lines_in,
	input  wire [7:0]  upper_address_lines,
	input  wire        accel_high_voltage_level,
	input  wire        accel_low_level,
	input  wire [1:0]  wrap_mode,
	input  wire        boot_at_top,
	input  wire        op_start,
	input  wire        op_is_erase,
	input  wire [5:0]  op_word_count,
	input  wire        op_done,
	output reg  [15:0] muxed_addr_data_lines_out,
	output reg         muxed_addr_data_lines_oe,
	output reg         ready,
	output reg  [22:0] latched_addr,
	output reg  [2:0]  busy_bank,
	output reg         bank_busy,
	output reg         unlock_bypass,
	output reg         accel_prog,
	output reg         op_refused,
	output reg  [22:0] erase_base,
	output reg  [22:0] erase_words,
	output reg  [15:0] write_word,
	output reg         write_strobe,
	output reg  [15:0] array_addr_word,
	output reg         last_word
);

// ----------------------------------------------------------------
// burst state
// ----------------------------------------------------------------
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_LAT  = 3'b010;
localparam [2:0] ST_DATA = 3'b100;

// ----------------------------------------------------------------
// burst registers
// ----------------------------------------------------------------

reg  [2:0]  state;
reg  [3:0]  lat_cnt;
reg  [22:0] burst_addr;
reg  [22:0] start_addr;
reg  [1:0]  wrap_sel;
reg  [22:0] next_burst_addr;
reg  [15:0] word_data;
wire [22:0] cap_addr = {upper_address_lines[6:0], muxed_addr_data_lines_in};
wire [2:0]  sector_bank = burst_addr[22:`BMFBI_BANK_SHIFT];
wire        sel = ~chip_enable_n;

// ----------------------------------------------------------------
// burst address step
// ----------------------------------------------------------------

// wrapped group arithmetic keeps upper bits fixed
always @* begin
	case (wrap_sel)
		// RQ17 wrap in group
		`BMFBI_WRAP_8:  next_burst_addr = {burst_addr[22:3], burst_addr[2:0] + 3'h1};
		`BMFBI_WRAP_16: next_burst_addr = {burst_addr[22:4], burst_addr[3:0] + 4'h1};
		// RQ16 continuous burst
		default:        next_burst_addr = burst_addr + 23'h000001;
	endcase
end

// ----------------------------------------------------------------
// array stand-in
// ----------------------------------------------------------------

// array word stand-in: address pattern, erased pattern in busy bank for the first burst word only
always @* begin
	// RQ20 busy bank undefined
	if (bank_busy && sector_bank == busy_bank)
		word_data = `BMFBI_ERASE_WORD;
	else
		word_data = burst_addr[15:0] ^ {13'h0000, burst_addr[22:20]};
end

// ----------------------------------------------------------------
// burst engine
// ----------------------------------------------------------------
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		// RQ7 reset to array read
		state                     <= ST_IDLE;
		lat_cnt                   <= 4'h0;
		burst_addr                <= 23'h000000;
		start_addr                <= 23'h000000;
		wrap_sel                  <= 2'h0;
		latched_addr              <= 23'h000000;
		muxed_addr_data_lines_out <= 16'h0000;
		muxed_addr_data_lines_oe  <= 1'b0;
		ready                     <= 1'b0;
		array_addr_word           <= 16'h0000;
		last_word                 <= 1'b0;
	end else begin
		last_word <= 1'b0;
		if (!sel) begin
			state                    <= ST_IDLE;
			ready                    <= 1'b0;
			muxed_addr_data_lines_oe <= 1'b0;
		// RQ1 latch on strobe low
		end else if (!address_valid_strobe_n) begin
			// RQ4 low bits muxed
			latched_addr             <= cap_addr;
			burst_addr               <= cap_addr;
			start_addr               <= cap_addr;
			wrap_sel                 <= wrap_mode;
			lat_cnt                  <= `BMFBI_LAT_CYCLES;
			state                    <= ST_LAT;
			ready                    <= 1'b0;
			muxed_addr_data_lines_oe <= 1'b0;
		end else begin
			// RQ5 strobe high holds address
			case (state)
				ST_LAT: begin
					// RQ19 ready low in latency
					ready <= 1'b0;
					if (lat_cnt == 4'h1) begin
						state                     <= ST_DATA;
						// RQ10 full word out
						muxed_addr_data_lines_out <= word_data;
						array_addr_word           <= burst_addr[15:0];
						muxed_addr_data_lines_oe  <= ~output_enable_n;
						// RQ6 ready with data
						ready                     <= 1'b1;
					end
					lat_cnt <= lat_cnt - 4'h1;
				end
				ST_DATA: begin
					// RQ18 stop before start word
					if (wrap_sel != `BMFBI_WRAP_CONT && next_burst_addr == start_addr) begin
						state     <= ST_IDLE;
						ready     <= 1'b0;
						last_word <= 1'b1;
						muxed_addr_data_lines_oe <= 1'b0;
					end else begin
						// RQ2 advance per edge
						burst_addr               <= next_burst_addr;
						muxed_addr_data_lines_out <= next_burst_addr[15:0] ^ {13'h0000, next_burst_addr[22:20]};
						array_addr_word          <= next_burst_addr[15:0];
						muxed_addr_data_lines_oe <= ~output_enable_n;
						ready                    <= 1'b1;
					end
				end
				ST_IDLE: begin
					ready                    <= 1'b0;
					muxed_addr_data_lines_oe <= 1'b0;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
end

// ----------------------------------------------------------------
// write and program control
// ----------------------------------------------------------------
wire [2:0]  op_bank  = latched_addr[22:`BMFBI_BANK_SHIFT];
wire        in_boot  = boot_at_top ? (latched_addr[22:16] == 7'h7F) : (latched_addr[22:16] == 7'h00);
wire        cnt_ok   = (op_word_count != 6'h00) && (op_word_count <= 6'h20);

// operation gating
wire        op_bad   = accel_low_level || bank_busy || (!op_is_erase && !cnt_ok);
wire        op_take  = op_start && !op_bad;

// ----------------------------------------------------------------
// acceleration input
// ----------------------------------------------------------------
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		accel_prog <= 1'b0;
	end else begin
		// RQ8 accelerated programming
		accel_prog <= accel_high_voltage_level;
	end
end

// bypass mode is sticky until reset
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		unlock_bypass <= 1'b0;
	end else begin
		// RQ8 enter unlock bypass
		unlock_bypass <= accel_high_voltage_level | unlock_bypass;
	end
end

// ----------------------------------------------------------------
// write capture
// ----------------------------------------------------------------
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		write_strobe <= 1'b0;
	end else begin
		// RQ11 full word in
		write_strobe <= sel && !write_enable_n && address_valid_strobe_n;
	end
end

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		write_word <= 16'h0000;
	end else begin
		write_word <= muxed_addr_data_lines_in;
	end
end

// ----------------------------------------------------------------
// operation acceptance
// ----------------------------------------------------------------
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		op_refused <= 1'b0;
	end else begin
		// RQ9 refuse when low
		// RQ15 one to thirty-two words
		op_refused <= op_start && op_bad;
	end
end

// ----------------------------------------------------------------
// bank occupancy
// ----------------------------------------------------------------
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		bank_busy <= 1'b0;
	end else if (op_take) begin
		// RQ12 one busy bank
		bank_busy <= 1'b1;
	end else if (op_done) begin
		bank_busy <= 1'b0;
	end
end

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		busy_bank <= 3'h0;
	end else if (op_take) begin
		busy_bank <= op_bank;
	end
end

// ----------------------------------------------------------------
// erase bounds
// ----------------------------------------------------------------
always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		erase_base <= 23'h000000;
	end else if (op_take && op_is_erase) begin
		// RQ13 sector base
		if (in_boot)
			erase_base <= {latched_addr[22:14], 14'h0000};
		else
			erase_base <= {latched_addr[22:16], 16'h0000};
	end
end

always @(posedge clk or negedge rstn) begin
	if (!rstn) begin
		erase_words <= 23'h000000;
	end else if (op_take && op_is_erase) begin
		// RQ14 sector sizes
		if (in_boot)
			erase_words <= `BMFBI_BOOT_SEC_WORDS;
		else
			erase_words <= `BMFBI_MAIN_SEC_WORDS;
	end
end

endmodule // bmfbi_device
`default_nettype wire

// File: bmfbi_assertions.sv
// port assertions for the burst flash bus interface
`timescale 1ns/1ps
`default_nettype none
module bmfbi_assertions (
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        chip_enable_n,
	input wire logic        address_valid_strobe_n,
	input wire logic [15:0] muxed_addr_data_lines_in,
	input wire logic [7:0]  upper_address_lines,
	input wire logic        accel_high_voltage_level,
	input wire logic        accel_low_level,
	input wire logic        op_start,
	input wire logic        op_is_erase,
	input wire logic [5:0]  op_word_count,
	input wire logic        ready,
	input wire logic [22:0] latched_addr,
	input wire logic        unlock_bypass,
	input wire logic        op_refused
);
	logic [22:0] cap;
	assign cap = {upper_address_lines[6:0], muxed_addr_data_lines_in};
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_latch;
		!chip_enable_n && !address_valid_strobe_n;
	endsequence
	sequence s_wait;
		s_latch ##1 (!chip_enable_n && address_valid_strobe_n)[*4];
	endsequence
	chk_addr_capture: assert property (s_latch |=> latched_addr == $past(cap))
		else $error("address not captured");
	chk_addr_hold: assert property (address_valid_strobe_n |=> $stable(latched_addr))
		else $error("address changed with strobe high");
	chk_ready_wait: assert property (s_wait |-> !ready)
		else $error("ready early in latency");
	chk_ready_first: assert property (s_wait |=> ready)
		else $error("ready missing after latency");
	chk_ready_abort: assert property (chip_enable_n |=> !ready)
		else $error("ready without chip enable");
	chk_refuse_low: assert property (op_start && accel_low_level |=> op_refused)
		else $error("operation not refused at low level");
	chk_refuse_count: assert property (op_start && !op_is_erase && !accel_low_level
		&& (op_word_count == 6'h00 || op_word_count > 6'h20) |=> op_refused) else $error("bad count accepted");
	chk_bypass_set: assert property (accel_high_voltage_level |=> unlock_bypass)
		else $error("bypass not entered");
	chk_bypass_keep: assert property (unlock_bypass |=> unlock_bypass)
		else $error("bypass dropped");
endmodule // bmfbi_assertions
bind bmfbi_device bmfbi_assertions chk (.clk, .rstn, .chip_enable_n, .address_valid_strobe_n,
	.muxed_addr_data_lines_in, .upper_address_lines, .accel_high_voltage_level, .accel_low_level,
	.op_start, .op_is_erase, .op_word_count, .ready, .latched_addr, .unlock_bypass, .op_refused);
`default_nettype wire

// File: bmfbi_host.sv
// host memory controller model for burst reads
`timescale 1ns/1ps
`default_nettype none
module bmfbi_host (
	input  wire logic        clk,
	output var  logic        chip_enable_n = 1'h1,
	output var  logic        output_enable_n = 1'h1,
	output var  logic        address_valid_strobe_n = 1'h1,
	output var  logic [15:0] muxed_addr_data_lines_in = 16'h0,
	output var  logic [7:0]  upper_address_lines = 8'h0
);
	// burst accesses only, no asynchronous ones
	// one strobe edge then inverted address driven on the lines
	task automatic start(input logic [22:0] a);
		@(posedge clk);
		chip_enable_n <= 1'h0;
		output_enable_n <= 1'h0;
		address_valid_strobe_n <= 1'h0;
		muxed_addr_data_lines_in <= a[15:0];
		upper_address_lines <= {1'h0, a[22:16]};
		@(posedge clk);
		address_valid_strobe_n <= 1'h1;
		muxed_addr_data_lines_in <= ~a[15:0];
	endtask
	task automatic stop;
		@(posedge clk);
		chip_enable_n <= 1'h1;
		output_enable_n <= 1'h1;
	endtask
endmodule // bmfbi_host
`default_nettype wire

// File: burst_mux_flash_bus_interface_test.sv
// self-checking bench for the burst flash bus interface
`timescale 1ns/1ps
`default_nettype none
module burst_mux_flash_bus_interface_test;
	logic clk = 1'h0, rstn = 1'h0, acc_hi = 1'h0, acc_lo = 1'h0, op_start = 1'h0, op_done = 1'h0;
	logic [1:0] wrap_mode = 2'h0;
	logic [5:0] cnt = 6'h0;
	wire logic ce_n, oe_n, avs_n, ready, oe, busy, bypass, refused, last_word;
	wire logic [15:0] din, dout;
	wire logic [7:0] up;
	int error_cnt = 0, n_tests = 0;
	bmfbi_host host (.clk, .chip_enable_n(ce_n), .output_enable_n(oe_n), .address_valid_strobe_n(avs_n),
		.muxed_addr_data_lines_in(din), .upper_address_lines(up));
	bmfbi_device DUT (.clk, .rstn, .chip_enable_n(ce_n), .output_enable_n(oe_n), .write_enable_n(1'h1),
		.address_valid_strobe_n(avs_n), .muxed_addr_data_lines_in(din), .upper_address_lines(up),
		.accel_high_voltage_level(acc_hi), .accel_low_level(acc_lo), .wrap_mode, .boot_at_top(1'h0),
		.op_start, .op_is_erase(1'h0), .op_word_count(cnt), .op_done, .muxed_addr_data_lines_out(dout),
		.muxed_addr_data_lines_oe(oe), .ready, .latched_addr(), .busy_bank(), .bank_busy(busy),
		.unlock_bypass(bypass), .accel_prog(), .op_refused(refused), .erase_base(), .erase_words(),
		.write_word(), .write_strobe(), .array_addr_word(), .last_word);
	always #5 clk = ~clk;
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic finish_test;
		$display("errors=%0d checks=%0d", error_cnt, n_tests);
		if (error_cnt == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic burst(input logic [22:0] a, input logic [1:0] m, input int n);
		logic [22:0] mk, w;
		int i;
		mk = (m == 2'h1) ? 23'h7 : (m == 2'h2) ? 23'hF : 23'h7FFFFF;
		@(posedge clk);
		wrap_mode <= m;
		host.start(a);
		for (i = 0; ready !== 1'h1; i++) begin
			if (i == 20) begin
				error_cnt++;
				finish_test;
			end
			@(posedge clk);
			#1;
		end
		check({15'h0, oe}, 16'h1);
		for (i = 0; i < n; i++) begin
			w = (a & ~mk) | ((a + i) & mk);
			check(dout, w[15:0] ^ {13'h0, w[22:20]});
			@(posedge clk);
			#1;
		end
		check({15'h0, last_word}, {15'h0, m != 2'h0});
		host.stop;
	endtask
	task automatic op(input logic lo, input logic [5:0] c, input logic exp);
		@(posedge clk);
		acc_lo <= lo;
		cnt <= c;
		op_start <= 1'h1;
		@(posedge clk);
		op_start <= 1'h0;
		#1 check({15'h0, refused}, {15'h0, exp});
	endtask
	task automatic t_bursts;
		burst(23'h30FFFE, 2'h0, 5);
		burst(23'h500005, 2'h1, 8);
		burst(23'h00000B, 2'h2, 16);
	endtask
	task automatic t_ops;
		op(1'h1, 6'h01, 1'h1);
		op(1'h0, 6'h00, 1'h1);
		op(1'h0, 6'h21, 1'h1);
		op(1'h0, 6'h20, 1'h0);
		check({15'h0, busy}, 16'h1);
		burst(23'h100002, 2'h1, 8);
		op(1'h0, 6'h01, 1'h1);
		@(posedge clk);
		op_done <= 1'h1;
		acc_hi <= 1'h1;
		@(posedge clk);
		op_done <= 1'h0;
		#1 check({14'h0, busy, bypass}, 16'h1);
	endtask
	task automatic t_reset;
		host.start(23'h012340);
		@(posedge clk);
		rstn <= 1'h0;
		acc_hi <= 1'h0;
		#1 check({14'h0, ready, bypass}, 16'h0);
		@(posedge clk);
		rstn <= 1'h1;
		host.stop;
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rstn <= 1'h1;
		t_bursts;
		t_ops;
		t_reset;
		burst(23'h700003, 2'h1, 8);
		finish_test;
	end
endmodule // burst_mux_flash_bus_interface_test
`default_nettype wire
